/* rtl/timer_pkg.sv */
// constants, field positions and carrier types of the 8-bit timer/counter
// assumes a byte-wide register port on the same clock as the counter
//
// Notes on behaviour
// - counter and both compare registers are 8-bit
// - three flags, each gated by own mask
// - three-bit clock select picks tick source
// - select zero stops counter, cpu access remains
// - cpu counter write beats any count step
// - bottom at zero, max at 255
// - top is max or compare a
// - three-bit waveform mode steers counting
// - overflow flag set where mode defines
// - match sets compare flag at next tick
// - flag clears on service or written one
// - output formed from match, top, bottom, modes
// - compare double buffered only in pwm modes
// - buffer copied only at top or bottom
// - cpu reaches buffer or active register
// - output mode zero leaves output unchanged
// - mode zero wraps, overflow when reaching zero
// - mode two clears on compare a match
// - counter write blocks next tick's matches
package timer_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int FLAG_W = 3;
    localparam int PRESC_W = 10;

    // register offsets on the byte port
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CMP_A = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CMP_B = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_FLAG = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h6;

    // field positions
    localparam int COM_A_LO = 6;
    localparam int COM_B_LO = 4;
    localparam int WGM_LO = 0;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int WGM2_BIT = 3;
    localparam int CS_LO = 0;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP_A = 1;
    localparam int FLG_CMP_B = 2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [PRESC_W-1:0] DIV8_MASK = 10'h007;
    localparam logic [PRESC_W-1:0] DIV64_MASK = 10'h03f;
    localparam logic [PRESC_W-1:0] DIV256_MASK = 10'h0ff;
    localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3ff;

    // waveform modes
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PHASE_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PHASE_CMPA = 3'h5;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

    // compare output modes
    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [1:0] {wave_plain, wave_fast, wave_phase} wave_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic tick;
        logic block;
        logic up;
        logic bottom_evt;
        logic update;
        wave_kind_t kind;
        logic [1:0] com;
        logic force_hit;
        logic [DATA_W-1:0] count;
    } cmp_ctrl_t;

    typedef struct packed {
        logic [DATA_W-1:0] active;
        logic [DATA_W-1:0] buffer;
        logic out;
    } cmp_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl_a;
        logic [DATA_W-1:0] ctrl_b;
        logic [DATA_W-1:0] count;
        logic down;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] masks;
        logic [2:0] ext_sync;
        logic [PRESC_W-1:0] presc;
        logic block;
        logic [DATA_W-1:0] rd_data;
    } timer_state_t;
endpackage

/* rtl/compare_unit.sv */
// one output compare unit: active and buffer register, waveform state
// assumes the counter step strobes arrive from the same clock domain
module compare_unit (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire timer_pkg::cmp_ctrl_t ctrl,
    input wire logic buffered,
    input wire logic cpu_wr,
    input wire logic [timer_pkg::DATA_W-1:0] cpu_data,
    output logic [timer_pkg::DATA_W-1:0] active_value,
    output logic [timer_pkg::DATA_W-1:0] cpu_view,
    output logic match_evt,
    output logic wave_out
);
    import timer_pkg::*;

    cmp_state_t st;
    cmp_state_t next_st;

    // match is sampled at the tick, so the flag lands one tick later
    always_comb begin
        next_st = st;
        match_evt = ctrl.tick & ~ctrl.block & (ctrl.count == st.active);
        if (cpu_wr) begin
            next_st.buffer = cpu_data;
            if (!buffered) begin
                next_st.active = cpu_data;
            end
        end
        // buffer moves only at the sequence turn point
        if (buffered && ctrl.update) begin
            next_st.active = st.buffer;
        end
        // com of zero falls through every branch untouched
        case (ctrl.kind)
            wave_plain: begin
                if (match_evt || ctrl.force_hit) begin
                    case (ctrl.com)
                        COM_TOGGLE: next_st.out = ~st.out;
                        COM_CLEAR: next_st.out = 1'b0;
                        COM_SET: next_st.out = 1'b1;
                        default: next_st.out = st.out;
                    endcase
                end
            end
            wave_fast: begin
                // bottom wins so compare equal to top gives a steady level
                if (ctrl.com[1] && match_evt) begin
                    next_st.out = ctrl.com[0];
                end
                if (ctrl.com[1] && ctrl.bottom_evt) begin
                    next_st.out = ~ctrl.com[0];
                end
            end
            wave_phase: begin
                if (ctrl.com[1] && match_evt) begin
                    next_st.out = ctrl.up ? ctrl.com[0] : ~ctrl.com[0];
                end
            end
            default: next_st.out = st.out;
        endcase
    end

    // state register, cleared on reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active_value = st.active;
    assign cpu_view = buffered ? st.buffer : st.active;
    assign wave_out = st.out;
endmodule

/* rtl/timer8_compare_pwm_counter.sv */
// 8-bit timer/counter with prescaler, external count input and two
// compare units; registers reached over a plain byte port
// assumes the port master keeps strobes one cycle wide, never both at once
module timer8_compare_pwm_counter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire timer_pkg::reg_req_t req,
    output logic [timer_pkg::DATA_W-1:0] rd_data,
    input wire logic ext_count_pin,
    input wire logic [timer_pkg::FLAG_W-1:0] irq_ack,
    output logic [timer_pkg::FLAG_W-1:0] irq_req,
    output logic compare_out_a,
    output logic compare_out_b
);
    import timer_pkg::*;

    // address match, used by every register write
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        hit = (addr == target);
    endfunction

    // pwm family of a waveform mode
    function automatic wave_kind_t kind_of(input logic [2:0] wgm);
        case (wgm)
            WGM_FAST_MAX, WGM_FAST_CMPA: kind_of = wave_fast;
            WGM_PHASE_MAX, WGM_PHASE_CMPA: kind_of = wave_phase;
            default: kind_of = wave_plain;
        endcase
    endfunction

    // one timer tick per source period
    function automatic logic tick_of(
        input logic [2:0] cs,
        input logic [PRESC_W-1:0] presc,
        input logic rise,
        input logic fall
    );
        case (cs)
            CS_DIV1: tick_of = 1'b1;
            CS_DIV8: tick_of = ((presc & DIV8_MASK) == DIV8_MASK);
            CS_DIV64: tick_of = ((presc & DIV64_MASK) == DIV64_MASK);
            CS_DIV256: tick_of = ((presc & DIV256_MASK) == DIV256_MASK);
            CS_DIV1024: tick_of = ((presc & DIV1024_MASK) == DIV1024_MASK);
            CS_EXT_FALL: tick_of = fall;
            CS_EXT_RISE: tick_of = rise;
            default: tick_of = 1'b0;
        endcase
    endfunction

    timer_state_t st;
    timer_state_t next_st;

    logic [2:0] wgm;
    logic [2:0] cs;
    wave_kind_t kind;
    logic top_from_a;
    logic [DATA_W-1:0] top_value;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic ovf_evt;
    logic bottom_evt;
    logic update;
    logic count_wr;
    logic buffered;
    logic [FLAG_W-1:0] set_mask;
    logic [FLAG_W-1:0] clr_mask;
    logic [1:0] cmp_wr;
    logic [1:0] cmp_force;
    logic [1:0] cmp_match;
    logic [1:0] cmp_out;
    logic [DATA_W-1:0] cmp_active [2];
    logic [DATA_W-1:0] cmp_view [2];
    cmp_ctrl_t cmp_ctrl [2];

    // mode decode from the two control registers
    always_comb begin
        wgm = {st.ctrl_b[WGM2_BIT], st.ctrl_a[WGM_LO +: 2]};
        cs = st.ctrl_b[CS_LO +: 3];
        kind = kind_of(wgm);
        top_from_a = (wgm == WGM_PHASE_CMPA) || (wgm == WGM_FAST_CMPA);
    end

    // double buffering only in the pwm families
    assign buffered = (kind != wave_plain);

    // top is max or the live compare a value
    assign top_value = top_from_a ? cmp_active[0] : COUNT_MAX;

    // external edges come from the second and third sync stages only
    assign ext_rise = st.ext_sync[1] & ~st.ext_sync[2];
    assign ext_fall = ~st.ext_sync[1] & st.ext_sync[2];

    // select zero yields no tick at all, so the counter holds
    assign tick = tick_of(cs, st.presc, ext_rise, ext_fall);

    // counter indications
    assign at_top = (st.count == top_value);
    assign at_bottom = (st.count == COUNT_BOTTOM);
    assign at_max = (st.count == COUNT_MAX);

    assign count_wr = req.wr & hit(req.addr, ADDR_COUNT);

    // per-unit strobes; force acts only in the non-pwm family
    always_comb begin
        cmp_wr[0] = req.wr & hit(req.addr, ADDR_CMP_A);
        cmp_wr[1] = req.wr & hit(req.addr, ADDR_CMP_B);
        cmp_force[0] = req.wr & hit(req.addr, ADDR_CTRL_B)
            & req.wdata[FORCE_A_BIT] & (kind == wave_plain);
        cmp_force[1] = req.wr & hit(req.addr, ADDR_CTRL_B)
            & req.wdata[FORCE_B_BIT] & (kind == wave_plain);
    end

    // main next-state: counter, direction, flags, registers, read data
    always_comb begin
        next_st = st;
        ovf_evt = 1'b0;
        bottom_evt = 1'b0;
        update = 1'b0;
        set_mask = '0;
        clr_mask = irq_ack;

        // free-running prescaler and pin synchroniser
        next_st.presc = st.presc + 1'b1;
        next_st.ext_sync = {st.ext_sync[1:0], ext_count_pin};

        // count step at each timer tick
        if (tick) begin
            case (kind)
                wave_plain: begin
                    if (wgm == WGM_CTC && st.count == cmp_active[0]) begin
                        next_st.count = COUNT_BOTTOM;
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                    // overflow in the tick that wraps to zero
                    ovf_evt = at_max;
                end
                wave_fast: begin
                    if (at_top) begin
                        next_st.count = COUNT_BOTTOM;
                        ovf_evt = 1'b1;
                        bottom_evt = 1'b1;
                        update = 1'b1;
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                end
                wave_phase: begin
                    if (!st.down) begin
                        if (at_top) begin
                            next_st.count = st.count - 1'b1;
                            next_st.down = 1'b1;
                            update = 1'b1;
                        end else begin
                            next_st.count = st.count + 1'b1;
                        end
                    end else if (at_bottom) begin
                        next_st.count = COUNT_ONE;
                        next_st.down = 1'b0;
                    end else begin
                        next_st.count = st.count - 1'b1;
                        // overflow as the count reaches bottom
                        ovf_evt = (st.count == COUNT_ONE);
                    end
                end
                default: next_st.count = st.count;
            endcase
            // the block covers exactly one tick after a count write
            next_st.block = 1'b0;
        end

        // cpu write wins over the step above, and arms the block
        if (count_wr) begin
            next_st.count = req.wdata;
            next_st.block = 1'b1;
        end

        // control and mask registers; force bits are strobes, not stored
        if (req.wr && hit(req.addr, ADDR_CTRL_A)) begin
            next_st.ctrl_a = req.wdata;
        end
        if (req.wr && hit(req.addr, ADDR_CTRL_B)) begin
            next_st.ctrl_b = req.wdata;
            next_st.ctrl_b[FORCE_A_BIT] = 1'b0;
            next_st.ctrl_b[FORCE_B_BIT] = 1'b0;
        end
        if (req.wr && hit(req.addr, ADDR_MASK)) begin
            next_st.masks = req.wdata[FLAG_W-1:0];
        end

        // flags: written one or service clears, a new event wins
        if (req.wr && hit(req.addr, ADDR_FLAG)) begin
            clr_mask = clr_mask | req.wdata[FLAG_W-1:0];
        end
        set_mask[FLG_OVF] = ovf_evt;
        set_mask[FLG_CMP_A] = cmp_match[0];
        set_mask[FLG_CMP_B] = cmp_match[1];
        next_st.flags = (st.flags & ~clr_mask) | set_mask;

        // read data stands only in the cycle after the strobe
        next_st.rd_data = '0;
        if (req.rd) begin
            case (req.addr)
                ADDR_CTRL_A: next_st.rd_data = st.ctrl_a;
                ADDR_CTRL_B: next_st.rd_data = st.ctrl_b;
                ADDR_COUNT: next_st.rd_data = st.count;
                ADDR_CMP_A: next_st.rd_data = cmp_view[0];
                ADDR_CMP_B: next_st.rd_data = cmp_view[1];
                ADDR_FLAG: next_st.rd_data = {5'h00, st.flags};
                ADDR_MASK: next_st.rd_data = {5'h00, st.masks};
                default: next_st.rd_data = '0;
            endcase
        end
    end

    // state register; reset leaves the clock select at stop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // the two compare units run independently of each other
    generate
        for (genvar g = 0; g < 2; g++) begin : g_cmp
            always_comb begin
                cmp_ctrl[g].tick = tick;
                cmp_ctrl[g].block = st.block;
                cmp_ctrl[g].up = ~st.down;
                cmp_ctrl[g].bottom_evt = bottom_evt;
                cmp_ctrl[g].update = update;
                cmp_ctrl[g].kind = kind;
                cmp_ctrl[g].com = (g == 0) ? st.ctrl_a[COM_A_LO +: 2]
                                           : st.ctrl_a[COM_B_LO +: 2];
                cmp_ctrl[g].force_hit = cmp_force[g];
                cmp_ctrl[g].count = st.count;
            end

            compare_unit u_cmp (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .ctrl(cmp_ctrl[g]),
                .buffered(buffered),
                .cpu_wr(cmp_wr[g]),
                .cpu_data(req.wdata),
                .active_value(cmp_active[g]),
                .cpu_view(cmp_view[g]),
                .match_evt(cmp_match[g]),
                .wave_out(cmp_out[g])
            );
        end
    endgenerate

    // outputs all come from flops or from gating of flops
    assign rd_data = st.rd_data;
    assign irq_req = st.flags & st.masks;
    assign compare_out_a = cmp_out[0];
    assign compare_out_b = cmp_out[1];
endmodule

/* bench/timer_props.sv */
// port checker for the 8-bit timer/counter, bound to the top module
// assumes one core_clk domain and the byte register port protocol
module timer_props
    import timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire timer_pkg::reg_req_t req,
    input wire logic [timer_pkg::DATA_W-1:0] rd_data,
    input wire logic ext_count_pin,
    input wire logic [timer_pkg::FLAG_W-1:0] irq_ack,
    input wire logic [timer_pkg::FLAG_W-1:0] irq_req,
    input wire logic compare_out_a,
    input wire logic compare_out_b
);
    typedef struct packed {
        logic [2:0] cs;
        logic [FLAG_W-1:0] mask;
        logic [1:0] com_a;
        logic [1:0] com_b;
    } shadow_t;
    shadow_t shadow;
    shadow_t next_shadow;
    logic stopped;

    // mirror of the control fields, taken from the writes themselves
    always_comb begin
        next_shadow = shadow;
        if (req.wr && req.addr == ADDR_CTRL_B) begin
            next_shadow.cs = req.wdata[CS_LO +: 3];
        end
        if (req.wr && req.addr == ADDR_MASK) begin
            next_shadow.mask = req.wdata[FLAG_W-1:0];
        end
        if (req.wr && req.addr == ADDR_CTRL_A) begin
            next_shadow.com_a = req.wdata[COM_A_LO +: 2];
            next_shadow.com_b = req.wdata[COM_B_LO +: 2];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow <= '0;
        end else begin
            shadow <= next_shadow;
        end
    end
    // no tick can land on an edge where the select field is zero
    assign stopped = (shadow.cs == CS_STOP);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_rd_idle_zero: assert property (!$past(req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read answer");
    a_reset_quiet: assert property ($rose(rst_n) |-> irq_req == 3'h0
        && !compare_out_a && !compare_out_b)
        else $error("outputs not quiet after reset release");
    a_stopped_hold: assert property (stopped && !req.wr
        && irq_ack == 3'h0 |=> $stable(irq_req) && $stable(compare_out_a)
        && $stable(compare_out_b))
        else $error("outputs moved while timer stopped");
    a_ack_clear: assert property (stopped && !req.wr
        && irq_ack != 3'h0 |=> (irq_req & $past(irq_ack)) == 3'h0)
        else $error("service did not clear flag");
    a_flag_w1c: assert property (stopped && req.wr
        && req.addr == ADDR_FLAG
        |=> ({5'h0, irq_req} & $past(req.wdata)) == 8'h00)
        else $error("written one did not clear flag");
    a_mask_gate: assert property ((irq_req & ~shadow.mask) == 3'h0)
        else $error("request raised with mask bit low");
    a_write_readback: assert property (req.wr
        && (req.addr == ADDR_COUNT
        || req.addr == ADDR_CMP_A || req.addr == ADDR_CMP_B)
        ##1 req.rd && req.addr == $past(req.addr)
        |=> rd_data == $past(req.wdata, 2))
        else $error("written value not read back");
    a_com_none_a: assert property (shadow.com_a == COM_NONE
        |=> $stable(compare_out_a))
        else $error("output a moved with mode none");
    a_com_none_b: assert property (shadow.com_b == COM_NONE
        |=> $stable(compare_out_b))
        else $error("output b moved with mode none");

    c_write_read: cover property (req.wr ##1 req.rd);
    c_flag_a: cover property ($rose(irq_req[FLG_CMP_A]));
    c_out_a: cover property ($rose(compare_out_a));
endmodule

bind timer8_compare_pwm_counter timer_props i_props (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
    .ext_count_pin(ext_count_pin), .irq_ack(irq_ack), .irq_req(irq_req),
    .compare_out_a(compare_out_a), .compare_out_b(compare_out_b)
);

/* bench/testbench.sv */
// self-checking bench for the 8-bit timer/counter
// assumes the package offsets and the one-cycle read answer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req = '0;
    logic [DATA_W-1:0] rd_data;
    logic ext_count_pin = 1'b0;
    logic [FLAG_W-1:0] irq_ack = '0;
    logic [FLAG_W-1:0] irq_req;
    logic compare_out_a;
    logic compare_out_b;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] got;
    int div_sh [8] = '{0, 0, 3, 6, 8, 10, 0, 0};
    // force bits read zero, unmapped place reads zero
    row_t rows [7] = '{'{ADDR_COUNT, 8'h5a, 8'h5a},
        '{ADDR_CMP_A, 8'ha5, 8'ha5}, '{ADDR_CMP_B, 8'h3c, 8'h3c},
        '{ADDR_MASK, 8'h07, 8'h07}, '{ADDR_CTRL_B, 8'hc8, 8'h08},
        '{ADDR_CTRL_A, 8'hf2, 8'hf2}, '{3'h7, 8'hff, 8'h00}};

    timer8_compare_pwm_counter i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
        .ext_count_pin(ext_count_pin), .irq_ack(irq_ack),
        .irq_req(irq_req), .compare_out_a(compare_out_a),
        .compare_out_b(compare_out_b)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write strobe stays up until the next task replaces the request
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '0;
        @(negedge core_clk);
        d = rd_data;
        @(posedge core_clk);
    endtask
    task automatic idle(input int n);
        req <= '0;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic see_irq(input logic [2:0] e);
        req <= '0;
        @(negedge core_clk);
        check({5'h0, irq_req}, {5'h0, e});
        @(posedge core_clk);
    endtask
    task automatic check_reset();
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), got);
            check(got, 8'h00);
        end
        // look at the flop outputs away from the edge that launches them
        @(negedge core_clk);
        check({3'h0, compare_out_a, compare_out_b, irq_req}, 8'h00);
        @(posedge core_clk);
    endtask

    // cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        check_reset();
        for (int i = 0; i < 7; i++) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, got);
            check(got, rows[i].exp);
        end
        wr_reg(ADDR_CTRL_A, 8'h00);
        wr_reg(ADDR_CTRL_B, 8'h00);
        // every nonzero clock select code over a fixed window of edges
        for (int c = 1; c < 8; c++) begin
            wr_reg(ADDR_COUNT, 8'h00);
            wr_reg(ADDR_CTRL_B, 8'(c));
            if (c < 6) begin
                idle(1023);
            end else begin
                idle(1);
                repeat (5) begin
                    ext_count_pin <= 1'b1;
                    repeat (3) @(posedge core_clk);
                    ext_count_pin <= 1'b0;
                    repeat (3) @(posedge core_clk);
                end
                idle(5); // synchroniser delay drains
            end
            wr_reg(ADDR_CTRL_B, 8'h00);
            rd_reg(ADDR_COUNT, got);
            check(got, (c < 6) ? 8'(1024 >> div_sh[c]) : 8'h05);
        end
        idle(20);
        rd_reg(ADDR_COUNT, got);
        check(got, 8'h05);
        // normal mode: match flags one tick late, overflow on wrap
        wr_reg(ADDR_FLAG, 8'h07);
        wr_reg(ADDR_CMP_A, 8'h03);
        wr_reg(ADDR_CMP_B, 8'h05);
        wr_reg(ADDR_COUNT, 8'h00);
        wr_reg(ADDR_CTRL_B, 8'(CS_DIV1));
        req <= '0;
        for (int n = 1; n <= 256; n++) begin
            @(posedge core_clk);
            @(negedge core_clk);
            check({5'h0, irq_req},
                {5'h0, n >= 6, n >= 4, n >= 256});
        end
        @(posedge core_clk);
        wr_reg(ADDR_CTRL_B, 8'h00);
        pulse_ack: begin
            irq_ack <= 3'b010;
            req <= '0;
            @(posedge core_clk);
            irq_ack <= 3'b000;
        end
        see_irq(3'b101);
        wr_reg(ADDR_FLAG, 8'h04);
        see_irq(3'b001);
        wr_reg(ADDR_MASK, 8'h00);
        see_irq(3'b000);
        rd_reg(ADDR_FLAG, got);
        check(got, 8'h01);
        wr_reg(ADDR_FLAG, 8'h01);
        rd_reg(ADDR_FLAG, got);
        check(got, 8'h00);
        // a count write equal to compare must not flag on the next tick
        wr_reg(ADDR_MASK, 8'h07);
        wr_reg(ADDR_CMP_A, 8'h20);
        wr_reg(ADDR_COUNT, 8'h20);
        wr_reg(ADDR_CTRL_B, 8'(CS_DIV1));
        repeat (4) see_irq(3'b000);
        wr_reg(ADDR_COUNT, 8'h80);
        rd_reg(ADDR_COUNT, got);
        check(got, 8'h80);
        wr_reg(ADDR_CTRL_B, 8'h00);
        // clear on match a, toggle a, unit b left alone
        wr_reg(ADDR_CTRL_A, {COM_TOGGLE, COM_NONE, 4'h2});
        wr_reg(ADDR_CMP_A, 8'h02);
        wr_reg(ADDR_CMP_B, 8'h01);
        wr_reg(ADDR_COUNT, 8'h00);
        wr_reg(ADDR_CTRL_B, 8'(CS_DIV1));
        req <= '0;
        for (int n = 1; n <= 9; n++) begin
            @(posedge core_clk);
            @(negedge core_clk);
            check({6'h0, compare_out_a, compare_out_b},
                {6'h0, 1'((n / 3) % 2), 1'b0});
        end
        // reset in mid-run
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        check_reset();
        // fast pwm: the buffered compare a only takes over at the wrap,
        // so the old value f8 still sets the output before it
        wr_reg(ADDR_CMP_A, 8'hf8);
        wr_reg(ADDR_CTRL_A, {COM_SET, COM_NONE, 4'h3});
        wr_reg(ADDR_CMP_A, 8'h10);
        wr_reg(ADDR_COUNT, 8'hf0);
        wr_reg(ADDR_CTRL_B, 8'(CS_DIV1));
        req <= '0;
        for (int n = 10; n <= 40; n += 10) begin
            repeat (10) @(posedge core_clk);
            @(negedge core_clk);
            check({7'h0, compare_out_a},
                {7'h0, n < 15 || n > 35});
        end
        test_done();
    end
endmodule
